/* File: rtl/hfsw_regs.sv */
// Register bank for HDLC FIFO watermarks, event flags and interrupt.
`timescale 1ns/1ps

module hfsw_regs
    import hfsw_pkg::*;
(
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    // HDLC datapath
    input  wire hfsw_hdlc_in_t hdlc_in,
    input  wire logic          tx_fifo_write,
    input  wire logic [8:0]    tx_fifo_bytes,
    input  wire logic [8:0]    rx_fifo_bytes,
    output logic               rx_flush,
    // Interrupt
    output logic               irq
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [8:0] level_of(input logic [2:0] code);
        level_of = LEVEL_BASE + (LEVEL_STEP * {6'h00, code});
    endfunction

    // The set is OR-ed in after the clear, so an event that lands on a clear is kept.
    function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
        sticky_next = (cur && !clr) || set;
    endfunction

    function automatic logic reg_at(input logic [11:0] addr, input logic [9:0] offset);
        reg_at = addr == {2'b00, offset};
    endfunction

    // ****************************************
    // Registers and decode
    // ****************************************
    logic [7:0]   control_r;
    logic [2:0]   tx_low_level_select;
    logic [2:0]   rx_high_level_select;
    hfsw_events_t events;
    logic         tx_packet_done_flag;
    logic         tx_starved_flag;
    logic         tx_below_level_flag;
    logic         rx_above_level_flag;
    logic         rx_abort_flag;
    logic         rx_packet_begin_flag;
    logic         rx_packet_finish_flag;
    logic         rx_overflow_flag;
    logic [7:0]   event_irq_enable_r;
    logic         link_ctrl_global_irq_en;
    logic         tx_below_level;
    logic         rx_above_level;
    logic         tx_below_level_d_r;
    logic         rx_above_level_d_r;
    logic         rx_in_packet_r;
    logic         rx_abort_armed_r;
    logic         tx_starve_armed_r;
    logic         rx_flush_r;
    logic [7:0]   set_vec;
    logic [7:0]   clr_vec;
    logic         wr_en;
    logic         rd_en;
    logic         wr_control;
    logic         wr_select;
    logic         wr_events;
    logic         wr_irq_en;
    logic         wr_master;
    logic         addr_ok;
    logic         abort_hit;
    logic         underrun;

    assign wr_en   = psel && penable && pwrite;
    // Read data is loaded in the setup cycle so that it stands through the access phase.
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign addr_ok = (paddr[11:10] == 2'b00) &&
                     ((paddr[9:0] == ADDR_CONTROL) || (paddr[9:0] == ADDR_WATERMARK_SEL) ||
                      (paddr[9:0] == ADDR_LIVE_STATUS) || (paddr[9:0] == ADDR_LATCHED_EVENTS) ||
                      (paddr[9:0] == ADDR_EVENT_IRQ_EN) || (paddr[9:0] == ADDR_MASTER_IRQ_EN));
    assign pslverr = psel && penable && !addr_ok;

    assign wr_control = wr_en && reg_at(paddr, ADDR_CONTROL);
    assign wr_select  = wr_en && reg_at(paddr, ADDR_WATERMARK_SEL);
    assign wr_events  = wr_en && reg_at(paddr, ADDR_LATCHED_EVENTS);
    assign wr_irq_en  = wr_en && reg_at(paddr, ADDR_EVENT_IRQ_EN);
    assign wr_master  = wr_en && reg_at(paddr, ADDR_MASTER_IRQ_EN);

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_r <= RST_CONTROL;
        end else if (wr_control) begin
            control_r <= pwdata[7:0];
        end
    end

    // Flush pulse on 0-to-1 of the reset bit only; holding it high does nothing more.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_flush_r <= 1'b0;
        end else begin
            rx_flush_r <= wr_control &&
                          pwdata[POS_RX_RESET] && !control_r[POS_RX_RESET];
        end
    end
    assign rx_flush = rx_flush_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_low_level_select <= RST_LEVEL_SEL;
        end else if (wr_select) begin
            tx_low_level_select <= pwdata[POS_TX_SEL_LSB +: 3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_high_level_select <= RST_LEVEL_SEL;
        end else if (wr_select) begin
            rx_high_level_select <= pwdata[POS_RX_SEL_LSB +: 3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_irq_enable_r <= RST_IRQ_EN;
        end else if (wr_irq_en) begin
            event_irq_enable_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_ctrl_global_irq_en <= 1'b0;
        end else if (wr_master) begin
            link_ctrl_global_irq_en <= pwdata[POS_GLOBAL_IRQ_EN];
        end
    end

    // ****************************************
    // Live watermark status
    // ****************************************
    assign tx_below_level = tx_fifo_bytes < level_of(tx_low_level_select);
    assign rx_above_level = rx_fifo_bytes > level_of(rx_high_level_select);

    // The delayed copies only serve edge detection; reads see the live compare.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_below_level_d_r <= 1'b0;
        end else begin
            tx_below_level_d_r <= tx_below_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_above_level_d_r <= 1'b0;
        end else begin
            rx_above_level_d_r <= rx_above_level;
        end
    end

    // ****************************************
    // Receive packet tracking
    // ****************************************
    // A flush abandons any packet in progress and rearms abort detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_in_packet_r <= 1'b0;
        end else if (rx_flush_r) begin
            rx_in_packet_r <= 1'b0;
        end else if (hdlc_in.rx_packet_begin) begin
            rx_in_packet_r <= 1'b1;
        end else if (hdlc_in.rx_flag_seen || abort_hit) begin
            rx_in_packet_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_abort_armed_r <= 1'b1;
        end else if (rx_flush_r || (hdlc_in.rx_flag_seen && !abort_hit)) begin
            rx_abort_armed_r <= 1'b1;
        end else if (abort_hit) begin
            rx_abort_armed_r <= 1'b0;
        end
    end
    assign abort_hit = hdlc_in.rx_ones_run7 && rx_in_packet_r && rx_abort_armed_r;

    // ****************************************
    // Transmit underrun tracking
    // ****************************************
    // Arming on each FIFO write stops an empty FIFO from flagging underrun every cycle.
    assign underrun = hdlc_in.tx_fifo_empty && tx_starve_armed_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_starve_armed_r <= 1'b0;
        end else if (tx_fifo_write) begin
            tx_starve_armed_r <= 1'b1;
        end else if (underrun || (hdlc_in.tx_fetch && hdlc_in.tx_message_last_tag)) begin
            tx_starve_armed_r <= 1'b0;
        end
    end

    // ****************************************
    // Latched events
    // ****************************************
    always_comb begin
        set_vec    = 8'h00;
        set_vec[0] = (hdlc_in.tx_fetch && hdlc_in.tx_message_last_tag) || underrun;
        set_vec[1] = underrun;
        set_vec[2] = tx_below_level && !tx_below_level_d_r;
        set_vec[3] = rx_above_level && !rx_above_level_d_r;
        set_vec[4] = abort_hit;
        set_vec[5] = hdlc_in.rx_packet_begin;
        set_vec[6] = hdlc_in.rx_flag_seen && rx_in_packet_r;
        set_vec[7] = hdlc_in.rx_overflow;
    end

    assign clr_vec = wr_events ? pwdata[7:0] : 8'h00;

    // One register per flag keeps each sticky bit's own set and clear easy to follow.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_packet_done_flag <= RST_EVENTS[0];
        end else begin
            tx_packet_done_flag <= sticky_next(tx_packet_done_flag, set_vec[0], clr_vec[0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_starved_flag <= RST_EVENTS[1];
        end else begin
            tx_starved_flag <= sticky_next(tx_starved_flag, set_vec[1], clr_vec[1]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_below_level_flag <= RST_EVENTS[2];
        end else begin
            tx_below_level_flag <= sticky_next(tx_below_level_flag, set_vec[2], clr_vec[2]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_above_level_flag <= RST_EVENTS[3];
        end else begin
            rx_above_level_flag <= sticky_next(rx_above_level_flag, set_vec[3], clr_vec[3]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_abort_flag <= RST_EVENTS[4];
        end else begin
            rx_abort_flag <= sticky_next(rx_abort_flag, set_vec[4], clr_vec[4]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_packet_begin_flag <= RST_EVENTS[5];
        end else begin
            rx_packet_begin_flag <= sticky_next(rx_packet_begin_flag, set_vec[5], clr_vec[5]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_packet_finish_flag <= RST_EVENTS[6];
        end else begin
            rx_packet_finish_flag <= sticky_next(rx_packet_finish_flag, set_vec[6], clr_vec[6]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_overflow_flag <= RST_EVENTS[7];
        end else begin
            rx_overflow_flag <= sticky_next(rx_overflow_flag, set_vec[7], clr_vec[7]);
        end
    end

    assign events = {rx_overflow_flag, rx_packet_finish_flag, rx_packet_begin_flag,
                     rx_abort_flag, rx_above_level_flag, tx_below_level_flag,
                     tx_starved_flag, tx_packet_done_flag};

    assign irq = link_ctrl_global_irq_en && |(events & event_irq_enable_r);

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                {2'b00, ADDR_CONTROL}:        prdata <= {24'h00_0000, control_r};
                {2'b00, ADDR_WATERMARK_SEL}:  prdata <= {25'h000_0000, rx_high_level_select,
                                                         1'b0, tx_low_level_select};
                {2'b00, ADDR_LIVE_STATUS}:    prdata <= {28'h000_0000, rx_above_level,
                                                         tx_below_level, 2'b00};
                {2'b00, ADDR_LATCHED_EVENTS}: prdata <= {24'h00_0000, events};
                {2'b00, ADDR_EVENT_IRQ_EN}:   prdata <= {24'h00_0000, event_irq_enable_r};
                {2'b00, ADDR_MASTER_IRQ_EN}:  prdata <= {31'h0000_0000, link_ctrl_global_irq_en};
                default:                      prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

/* File: rtl/hfsw_pkg.sv */
// Package for the HDLC FIFO status and watermark register bank.
package hfsw_pkg;

    // ****************************************
    // Register byte addresses
    // ****************************************
    // Printed offsets are not all multiples of four, so they are indices.
    localparam logic [7:0]  IDX_CONTROL        = 8'h50;
    localparam logic [7:0]  IDX_WATERMARK_SEL  = 8'h51;
    localparam logic [7:0]  IDX_LIVE_STATUS    = 8'h54;
    localparam logic [7:0]  IDX_LATCHED_EVENTS = 8'h55;
    localparam logic [7:0]  IDX_EVENT_IRQ_EN   = 8'h56;
    localparam logic [7:0]  IDX_MASTER_IRQ_EN  = 8'h58;
    localparam logic [9:0]  ADDR_CONTROL        = {IDX_CONTROL, 2'b00};
    localparam logic [9:0]  ADDR_WATERMARK_SEL  = {IDX_WATERMARK_SEL, 2'b00};
    localparam logic [9:0]  ADDR_LIVE_STATUS    = {IDX_LIVE_STATUS, 2'b00};
    localparam logic [9:0]  ADDR_LATCHED_EVENTS = {IDX_LATCHED_EVENTS, 2'b00};
    localparam logic [9:0]  ADDR_EVENT_IRQ_EN   = {IDX_EVENT_IRQ_EN, 2'b00};
    localparam logic [9:0]  ADDR_MASTER_IRQ_EN  = {IDX_MASTER_IRQ_EN, 2'b00};

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int          POS_RX_RESET       = 7;
    localparam int          POS_TX_SEL_LSB     = 0;
    localparam int          POS_RX_SEL_LSB     = 4;
    localparam int          POS_TX_BELOW       = 2;
    localparam int          POS_RX_ABOVE       = 3;
    localparam int          POS_GLOBAL_IRQ_EN  = 0;
    localparam logic [7:0]  RST_CONTROL        = 8'h00;
    localparam logic [2:0]  RST_LEVEL_SEL      = 3'h0;
    localparam logic [7:0]  RST_EVENTS         = 8'h00;
    localparam logic [7:0]  RST_IRQ_EN         = 8'h00;

    // ****************************************
    // Watermark arithmetic
    // ****************************************
    localparam logic [8:0]  LEVEL_BASE         = 9'h010;
    localparam logic [8:0]  LEVEL_STEP         = 9'h020;

    // Latched event bits, high to low.
    typedef struct packed {
        logic rx_overflow_flag;
        logic rx_packet_finish_flag;
        logic rx_packet_begin_flag;
        logic rx_abort_flag;
        logic rx_above_level_flag;
        logic tx_below_level_flag;
        logic tx_starved_flag;
        logic tx_packet_done_flag;
    } hfsw_events_t;

    // Event strobes from the HDLC datapath.
    typedef struct packed {
        logic tx_fetch;
        logic tx_message_last_tag;
        logic tx_fifo_empty;
        logic rx_ones_run7;
        logic rx_flag_seen;
        logic rx_packet_begin;
        logic rx_overflow;
    } hfsw_hdlc_in_t;

endpackage

/* File: tb/hfsw_regs_properties.sv */
// Concurrent checks for the HDLC watermark and event register bank.
`timescale 1ns/1ps
module hfsw_regs_properties
    import hfsw_pkg::*;
(
    // Clock, reset and APB
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic          pready,
    input wire logic [31:0]   prdata,
    input wire logic          pslverr,
    // HDLC side and interrupt
    input wire hfsw_hdlc_in_t hdlc_in,
    input wire logic          rx_flush,
    input wire logic          irq
);
    logic       wr;
    logic       mapped;
    logic       ctl7_r;
    logic [7:0] ien_r;
    logic       mst_r;
    assign wr = psel && penable && pwrite;
    assign mapped = paddr[11:10] == 2'b00 && paddr[9:0] inside {ADDR_CONTROL,
        ADDR_WATERMARK_SEL, ADDR_LIVE_STATUS, ADDR_LATCHED_EVENTS, ADDR_EVENT_IRQ_EN,
        ADDR_MASTER_IRQ_EN};
    // Shadows of the enables let irq be judged without reading them back.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl7_r <= 1'b0;
            ien_r  <= 8'h00;
            mst_r  <= 1'b0;
        end else if (wr && mapped) begin
            if (paddr[9:0] == ADDR_CONTROL) ctl7_r <= pwdata[7];
            if (paddr[9:0] == ADDR_EVENT_IRQ_EN) ien_r <= pwdata[7:0];
            if (paddr[9:0] == ADDR_MASTER_IRQ_EN) mst_r <= pwdata[0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (pready) else $error("pready low");
    a_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr does not follow the address map");
    a_flush_pulse: assert property (rx_flush |=> !rx_flush)
        else $error("rx_flush longer than one cycle");
    a_flush_cause: assert property (rx_flush == $past(wr && paddr[9:0] == ADDR_CONTROL
        && paddr[11:10] == 2'b00 && pwdata[7] && !ctl7_r)) else $error("rx_flush mismatch");
    a_irq_gated: assert property (irq |-> mst_r && ien_r != 8'h00)
        else $error("irq without enables");
    a_master_off: assert property (wr && mapped && paddr[9:0] == ADDR_MASTER_IRQ_EN
        && !pwdata[0] |=> !irq) else $error("irq stays after master disable");
    a_ovf_irq: assert property (hdlc_in.rx_overflow && ien_r[7] && mst_r && !wr
        |=> irq) else $error("overflow did not raise irq");
    a_live_bits: assert property (psel && penable && !pwrite
        && paddr == {2'b00, ADDR_LIVE_STATUS} |-> (prdata & 32'hFFFF_FFF3) == 32'h0000_0000)
        else $error("live status has stray bits");
endmodule
bind hfsw_regs hfsw_regs_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .hdlc_in(hdlc_in), .rx_flush(rx_flush), .irq(irq));

/* File: tb/hfsw_regs_bench.sv */
// Self-checking testbench for the HDLC watermark and event register bank.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module hfsw_regs_bench
    import hfsw_pkg::*;
;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rdat;
    hfsw_hdlc_in_t hdlc_in;
    logic          tx_fifo_write, rx_flush, irq, serr;
    logic [8:0]    tx_fifo_bytes, rx_fifo_bytes;
    int            errors = 0;
    int            n_tests = 0;
    int            flushes = 0;
    hfsw_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .hdlc_in(hdlc_in), .tx_fifo_write(tx_fifo_write),
        .tx_fifo_bytes(tx_fifo_bytes), .rx_fifo_bytes(rx_fifo_bytes), .rx_flush(rx_flush),
        .irq(irq));
    // Counted on the falling edge so the tally never races the bench tasks.
    always @(negedge pclk) if (rx_flush === 1'b1) flushes++;
    task automatic finish_test();
        $display("compares %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                        input hfsw_hdlc_in_t p);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {2'b00, a};
        pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        hdlc_in <= p;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            errors++;
            finish_test();
        end
        rdat = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        hdlc_in <= '0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, '0);
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00, '0);
        `CHK(rdat, {24'h00_0000, e})
    endtask
    task automatic pulse(input logic [7:0] v);
        hdlc_in       <= hfsw_hdlc_in_t'(v[6:0]);
        tx_fifo_write <= v[7];
        @(posedge pclk);
        hdlc_in       <= '0;
        tx_fifo_write <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_reset();
        rd_chk(ADDR_LATCHED_EVENTS, 8'h00);
        rd_chk(ADDR_EVENT_IRQ_EN, 8'h00);
        xfer(1'b0, 10'h3FC, 8'h00, '0);
        `CHK({serr, rdat}, 33'h0_0000_0000 | 33'h1_0000_0000)
        $display("test reset done");
    endtask
    task automatic t_levels();
        int thr;
        for (int n = 0; n < 8; n++) begin
            thr = 16 + 32 * n;
            wr(ADDR_WATERMARK_SEL, {1'b0, n[2:0], 1'b0, n[2:0]});
            tx_fifo_bytes <= 9'(thr - 1);
            rx_fifo_bytes <= 9'(thr + 1);
            repeat (2) @(posedge pclk);
            rd_chk(ADDR_LIVE_STATUS, 8'h0C);
            tx_fifo_bytes <= 9'(thr);
            rx_fifo_bytes <= 9'(thr);
            repeat (2) @(posedge pclk);
            rd_chk(ADDR_LIVE_STATUS, 8'h00);
        end
        wr(ADDR_LATCHED_EVENTS, 8'h00);
        rd_chk(ADDR_LATCHED_EVENTS, 8'h0C);
        wr(ADDR_LATCHED_EVENTS, 8'h0C);
        rd_chk(ADDR_LATCHED_EVENTS, 8'h00);
        $display("test levels done");
    endtask
    task automatic t_events();
        logic [7:0] stim [18] = '{8'h08, 8'h02, 8'h04, 8'h02, 8'h08, 8'h08, 8'h04, 8'h02,
                                  8'h08, 8'h02, 8'h08, 8'h04, 8'h10, 8'h80, 8'h10, 8'h10,
                                  8'h60, 8'h01};
        logic [7:0] expd [18] = '{8'h00, 8'h20, 8'h40, 8'h20, 8'h10, 8'h00, 8'h00, 8'h20,
                                  8'h10, 8'h20, 8'h00, 8'h40, 8'h00, 8'h00, 8'h03, 8'h00,
                                  8'h01, 8'h80};
        for (int i = 0; i < 18; i++) begin
            pulse(stim[i]);
            xfer(1'b0, ADDR_LATCHED_EVENTS, 8'h00, '0);
            `CHK(rdat[7:0], expd[i])
            wr(ADDR_LATCHED_EVENTS, 8'hFF);
        end
        $display("test events done");
    endtask
    task automatic t_irq();
        pulse(8'h01);
        wr(ADDR_EVENT_IRQ_EN, 8'h80);
        `CHK(irq, 1'b0)
        wr(ADDR_MASTER_IRQ_EN, 8'h01);
        `CHK(irq, 1'b1)
        wr(ADDR_EVENT_IRQ_EN, 8'h7F);
        `CHK(irq, 1'b0)
        wr(ADDR_EVENT_IRQ_EN, 8'h80);
        wr(ADDR_LATCHED_EVENTS, 8'h7F);
        `CHK(irq, 1'b1)
        wr(ADDR_MASTER_IRQ_EN, 8'h00);
        `CHK(irq, 1'b0)
        wr(ADDR_MASTER_IRQ_EN, 8'h01);
        wr(ADDR_LATCHED_EVENTS, 8'h80);
        `CHK(irq, 1'b0)
        pulse(8'h01);
        `CHK(irq, 1'b1)
        wr(ADDR_LATCHED_EVENTS, 8'h80);
        xfer(1'b1, ADDR_LATCHED_EVENTS, 8'h80, hfsw_hdlc_in_t'(7'h01));
        `CHK(irq, 1'b1)
        wr(ADDR_LATCHED_EVENTS, 8'h80);
        $display("test irq done");
    endtask
    task automatic t_flush();
        pulse(8'h02);
        wr(ADDR_CONTROL, 8'h80);
        `CHK(flushes, 1)
        pulse(8'h08);
        rd_chk(ADDR_LATCHED_EVENTS, 8'h20);
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_CONTROL, 8'h00);
        `CHK(flushes, 1)
        wr(ADDR_CONTROL, 8'h80);
        `CHK(flushes, 2)
        $display("test flush done");
    endtask
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        hdlc_in = '0;
        tx_fifo_write = 1'b0;
        tx_fifo_bytes = 9'h064;
        rx_fifo_bytes = 9'h000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_levels();
        t_events();
        t_irq();
        t_flush();
        finish_test();
    end
endmodule
